// *** include/csb_consts.vh ***
// Constants for the compare, skip and branch unit
`ifndef CSB_CONSTS_VH
`define CSB_CONSTS_VH
`define OP_NONE               4'h0
`define OP_COMPARE_CARRY      4'h1
`define OP_COMPARE_IMM        4'h2
`define OP_SKIP_REG_CLEAR     4'h3
`define OP_SKIP_REG_SET       4'h4
`define OP_SKIP_IO_CLEAR      4'h5
`define OP_SKIP_IO_SET        4'h6
`define OP_BRANCH_FLAG_SET    4'h7
`define OP_BRANCH_FLAG_CLEAR  4'h8
`define FLAG_C                3'h0
`define FLAG_Z                3'h1
`define FLAG_N                3'h2
`define FLAG_V                3'h3
`define FLAG_S                3'h4
`define FLAG_H                3'h5
`define OFFSET_W              7
`define SKIP_SHORT_WORDS      2'h2
`define SKIP_LONG_WORDS       2'h3
`endif

// *** rtl/compare_skip_branch_unit.v ***
// Executes compare, bit skip and conditional relative branch instructions
`timescale 1ns/1ps
`default_nettype none
module compare_skip_branch_unit
#(
	parameter PC_W = 16
)
(
	input  wire            i_clk,
	input  wire            i_sys_rst,
	input  wire            i_issue,
	input  wire [3:0]      i_op,
	input  wire [7:0]      i_dest_work_reg,
	input  wire [7:0]      i_source_work_reg,
	input  wire [7:0]      i_imm,
	input  wire [7:0]      i_io_reg,
	input  wire [2:0]      i_bit_sel,
	input  wire [6:0]      i_offset,
	input  wire            i_next_is_long,
	input  wire [PC_W-1:0] i_pc,
	input  wire [7:0]      i_status_flag_register,
	output reg  [7:0]      o_status_flag_register,
	output reg             o_flags_we,
	output reg  [PC_W-1:0] o_pc,
	output reg             o_pc_we,
	output reg  [1:0]      o_cycles,
	output reg             o_done
);
`include "csb_consts.vh"
	localparam ST_IDLE = 1'b0;
	localparam ST_WAIT = 1'b1;

	wire [7:0] cmp_flags;
	reg        state_q;
	reg        state_d;
	reg  [1:0] wait_q;
	reg  [1:0] wait_d;
	reg  [PC_W-1:0] pc_d;
	reg        pc_we_d;
	reg  [7:0] flags_d;
	reg        flags_we_d;
	reg  [1:0] cycles_d;
	reg        done_d;
	reg        taken;
	reg        skip_bit;
	reg  [PC_W-1:0] disp;

	csb_compare u_cmp
	(
		.i_lhs       (i_dest_work_reg),
		.i_rhs       (i_op == `OP_COMPARE_IMM ? i_imm : i_source_work_reg),
		.i_use_carry (i_op == `OP_COMPARE_CARRY),
		.i_flags     (i_status_flag_register),
		.o_flags     (cmp_flags)
	);

	always @*
	begin
		// Sign extension lets branches reach backward as well as forward
		disp = {{(PC_W-`OFFSET_W){i_offset[`OFFSET_W-1]}}, i_offset};
		skip_bit = 1'b0;
		taken = 1'b0;
		state_d = state_q;
		wait_d = wait_q;
		pc_d = o_pc;
		pc_we_d = 1'b0;
		flags_d = o_status_flag_register;
		flags_we_d = 1'b0;
		cycles_d = o_cycles;
		done_d = 1'b0;
		case (state_q)
		ST_IDLE:
		begin
			if (i_issue)
			begin
				case (i_op)
				`OP_COMPARE_CARRY, `OP_COMPARE_IMM:
				begin
					flags_d = cmp_flags;
					flags_we_d = 1'b1;
					cycles_d = 2'h1;
				end
				`OP_SKIP_REG_CLEAR, `OP_SKIP_REG_SET,
				`OP_SKIP_IO_CLEAR, `OP_SKIP_IO_SET:
				begin
					if (i_op == `OP_SKIP_REG_CLEAR || i_op == `OP_SKIP_REG_SET)
						skip_bit = i_source_work_reg[i_bit_sel];
					else
						skip_bit = i_io_reg[i_bit_sel];
					if (i_op == `OP_SKIP_REG_CLEAR || i_op == `OP_SKIP_IO_CLEAR)
						taken = ~skip_bit;
					else
						taken = skip_bit;
					if (taken)
					begin
						pc_d = i_pc + (i_next_is_long ?
							{{(PC_W-2){1'b0}}, `SKIP_LONG_WORDS} :
							{{(PC_W-2){1'b0}}, `SKIP_SHORT_WORDS});
						cycles_d = i_next_is_long ? 2'h3 : 2'h2;
					end
					else
					begin
						pc_d = i_pc + {{(PC_W-1){1'b0}}, 1'b1};
						cycles_d = 2'h1;
					end
				end
				`OP_BRANCH_FLAG_SET, `OP_BRANCH_FLAG_CLEAR:
				begin
					// Fixed-flag and signed branches arrive here by flag index:
					// equal/not equal on Z, carry/lower/higher on C,
					// minus/plus on N, signed ge/lt on S = N xor V
					if (i_op == `OP_BRANCH_FLAG_SET)
						taken = i_status_flag_register[i_bit_sel];
					else
						taken = ~i_status_flag_register[i_bit_sel];
					if (taken)
					begin
						pc_d = i_pc + disp + {{(PC_W-1){1'b0}}, 1'b1};
						cycles_d = 2'h2;
					end
					else
					begin
						pc_d = i_pc + {{(PC_W-1){1'b0}}, 1'b1};
						cycles_d = 2'h1;
					end
				end
				default:
					cycles_d = 2'h1;
				endcase
				// Flags stay untouched for skips and branches
				if (cycles_d == 2'h1)
				begin
					pc_we_d = (i_op != `OP_COMPARE_CARRY) && (i_op != `OP_COMPARE_IMM)
						&& (i_op != `OP_NONE) && (i_op <= `OP_BRANCH_FLAG_CLEAR);
					done_d = 1'b1;
				end
				else
				begin
					state_d = ST_WAIT;
					wait_d = cycles_d - 2'h1;
				end
			end
		end
		ST_WAIT:
		begin
			// PC moves on the last cycle so the core stalls until then
			wait_d = wait_q - 2'h1;
			if (wait_q == 2'h1)
			begin
				pc_we_d = 1'b1;
				done_d = 1'b1;
				state_d = ST_IDLE;
			end
		end
		default:
			state_d = ST_IDLE;
		endcase
	end

	always @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			state_q <= ST_IDLE;
			wait_q <= 2'h0;
			o_pc <= {PC_W{1'b0}};
			o_pc_we <= 1'b0;
			o_status_flag_register <= 8'h00;
			o_flags_we <= 1'b0;
			o_cycles <= 2'h0;
			o_done <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			wait_q <= wait_d;
			o_pc <= pc_d;
			o_pc_we <= pc_we_d;
			o_status_flag_register <= flags_d;
			o_flags_we <= flags_we_d;
			o_cycles <= cycles_d;
			o_done <= done_d;
		end
	end
endmodule
`default_nettype wire

// *** rtl/csb_compare.v ***
// Subtractor that forms compare flags without storing a difference
`timescale 1ns/1ps
`default_nettype none
module csb_compare
(
	input  wire [7:0] i_lhs,
	input  wire [7:0] i_rhs,
	input  wire       i_use_carry,
	input  wire [7:0] i_flags,
	output reg  [7:0] o_flags
);
`include "csb_consts.vh"
	reg [7:0] diff;
	reg       c_in;
	reg       zero;
	always @*
	begin
		c_in = i_use_carry & i_flags[`FLAG_C];
		diff = i_lhs - i_rhs - {7'h00, c_in};
		// With carry the zero flag only stays set, so multi-byte compares chain
		zero = (diff == 8'h00) & (i_use_carry ? i_flags[`FLAG_Z] : 1'b1);
		o_flags = i_flags;
		o_flags[`FLAG_H] = (~i_lhs[3] & i_rhs[3]) | (i_rhs[3] & diff[3])
			| (diff[3] & ~i_lhs[3]);
		o_flags[`FLAG_V] = (i_lhs[7] & ~i_rhs[7] & ~diff[7])
			| (~i_lhs[7] & i_rhs[7] & diff[7]);
		o_flags[`FLAG_N] = diff[7];
		o_flags[`FLAG_Z] = zero;
		o_flags[`FLAG_C] = (~i_lhs[7] & i_rhs[7]) | (i_rhs[7] & diff[7])
			| (diff[7] & ~i_lhs[7]);
		o_flags[`FLAG_S] = diff[7] ^ o_flags[`FLAG_V];
	end
endmodule
`default_nettype wire

// *** sim/compare_skip_branch_unit_bench.sv ***
// Random self-checking bench for the compare, skip and branch unit
`timescale 1ns/1ps
`default_nettype none
module compare_skip_branch_unit_bench;
	reg         i_clk = '0, i_sys_rst = '1, i_issue = '0, lg = '0, t, v;
	reg  [3:0]  op = 4'h1;
	reg  [7:0]  dw = '0, sw = '0, im = '0, io = '0, fl = '0, b;
	reg  [2:0]  bs = '0;
	reg  [6:0]  k = '0;
	reg  [15:0] pc = '0;
	reg  [95:0] r;
	reg  [8:0]  d;
	reg  [4:0]  h;
	reg  [15:0] ep;
	reg         c;
	wire [7:0]  f;
	wire [15:0] o_pc;
	wire [1:0]  o_cycles;
	wire        o_done, o_pc_we, o_flags_we;
	integer     seed = 83, mismatches = 0, tests_run = 0, i, n, ec;
	compare_skip_branch_unit i_compare_skip_branch_unit (.i_clk, .i_sys_rst,
		.i_issue, .i_op(op), .i_dest_work_reg(dw), .i_source_work_reg(sw),
		.i_imm(im), .i_io_reg(io), .i_bit_sel(bs), .i_offset(k),
		.i_next_is_long(lg), .i_pc(pc), .i_status_flag_register(fl),
		.o_status_flag_register(f), .o_flags_we, .o_pc, .o_pc_we, .o_cycles,
		.o_done);
	always #4 i_clk = ~i_clk;
	task check(input [31:0] s, input [31:0] e);
	begin
		tests_run = tests_run + 1;
		if (s !== e)
		begin
			mismatches = mismatches + 1;
			$display("MISMATCH at %0t: saw %h want %h", $time, s, e);
		end
	end
	endtask
	task finish_test;
	begin
		$display("%0d checks, %0d mismatches", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	initial
	begin
		#40000;
		mismatches = mismatches + 1;
		finish_test;
	end
	initial
	begin
		repeat (8) @(posedge i_clk);
		#1 i_sys_rst = 1'b0;
		// Next issue goes out in the done cycle, so runs are back to back
		for (i = 0; i < 300; i = i + 1)
		begin
			r = {$random(seed), $random(seed), $random(seed)};
			{dw, sw, im, io, bs, k, lg, pc, fl} = r[66:0];
			op = {1'b0, r[69:67]} + 4'h1;
			// Now and then a code the unit must treat as a no-op
			if (i % 40 == 39)
				op = i[6] ? 4'hf : 4'h0;
			if (i < 4)
			begin
				k = 7'h40;
				im = dw;
				lg = i[0];
			end
			// Callers keep S equal to N xor V
			fl[4] = fl[2] ^ fl[3];
			i_issue = 1'b1;
			@(posedge i_clk);
			// Issue stays up into the done cycle of a one-cycle op
			#1 n = 1;
			while (o_done !== 1'b1 && n < 4)
			begin
				i_issue = 1'b0;
				@(posedge i_clk);
				#1 n = n + 1;
			end
			b = op == 4'h1 ? sw : im;
			c = op == 4'h1 && fl[0];
			d = {1'b0, dw} - b - c;
			h = {1'b0, dw[3:0]} - b[3:0] - c;
			v = (dw[7] ^ b[7]) & (d[7] ^ dw[7]);
			t = (op < 4'h5 ? sw[bs] : op < 4'h7 ? io[bs] : fl[bs])
				^ op[0] ^ (op > 4'h6);
			ec = op < 4'h3 || op > 4'h8 || !t ? 1 : op < 4'h7 ? 2 + lg : 2;
			// Sixteen bits on purpose: the PC wraps like the real counter
			ep = !t ? pc + 16'h1 : op < 4'h7 ? pc + 16'h2 + lg
				: pc + {{9{k[6]}}, k} + 16'h1;
			check(n, ec);
			check(o_cycles, ec);
			check(o_flags_we, op == 4'h1 || op == 4'h2);
			check(o_pc_we, op > 4'h2 && op < 4'h9);
			if (op == 4'h1 || op == 4'h2)
				check(f, {fl[7:6], h[4], d[7] ^ v, v, d[7],
					d[7:0] == 8'h0 && (op[1] || fl[1]), d[8]});
			else if (op != 4'h0 && op < 4'h9)
				check(o_pc, ep);
		end
		$display("Random run of %0d ops done", i);
		// Reset in mid-skip must abort it: no late done or PC load
		op = 4'h4;
		sw = 8'h01;
		bs = 3'h0;
		lg = 1'b1;
		i_issue = 1'b1;
		@(posedge i_clk);
		#1 i_issue = 1'b0;
		@(posedge i_clk);
		#1 i_sys_rst = 1'b1;
		repeat (2) @(posedge i_clk);
		#1 i_sys_rst = 1'b0;
		check({o_done, o_pc_we, o_flags_we, o_cycles}, 5'h00);
		check({f, o_pc}, 24'h000000);
		@(posedge i_clk);
		#1 check(o_done, 1'b0);
		$display("Mid-run reset test done");
		finish_test;
	end
endmodule
`default_nettype wire

// *** sim/csb_unit_assertions.sv ***
// Port assertions for the compare, skip and branch unit
`timescale 1ns/1ps
`default_nettype none
module csb_checker #(parameter PC_W = 16) (
	input wire logic            i_clk, i_sys_rst, i_issue, i_next_is_long,
	input wire logic            o_done, o_pc_we, o_flags_we,
	input wire logic [3:0]      i_op,
	input wire logic [7:0]      i_source_work_reg, i_io_reg,
	input wire logic [7:0]      i_status_flag_register,
	input wire logic [2:0]      i_bit_sel,
	input wire logic [6:0]      i_offset,
	input wire logic [PC_W-1:0] i_pc, o_pc
);
	logic idle_q;
	// An issue counts only while idle or in the finishing cycle
	wire acc = i_issue && (idle_q || o_done);
	wire ctl = acc && i_op > 4'h2 && i_op < 4'h9;
	wire t = (i_op < 4'h5 ? i_source_work_reg[i_bit_sel] : i_op < 4'h7 ?
		i_io_reg[i_bit_sel] : i_status_flag_register[i_bit_sel])
		^ i_op[0] ^ (i_op > 4'h6);
	wire [PC_W-1:0] tgt = i_pc + {{(PC_W-7){i_offset[6]}}, i_offset} + 1'b1;
	always @(posedge i_clk)
		idle_q <= i_sys_rst || (!acc && (idle_q || o_done));
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	cmp_one_cycle_a: assert property (acc && i_op inside {4'h1, 4'h2}
		|=> o_done && o_flags_we && !o_pc_we) else $error("compare timing");
	skip_short_a: assert property (ctl && t && i_op < 4'h7
		&& !i_next_is_long |=> !o_done ##1 o_pc_we && o_done
		&& o_pc == $past(i_pc, 2) + 2'h2) else $error("short skip");
	skip_long_a: assert property (ctl && t && i_op < 4'h7
		&& i_next_is_long |=> !o_done [*2] ##1 o_pc_we && o_done
		&& o_pc == $past(i_pc, 3) + 2'h3) else $error("long skip");
	branch_taken_a: assert property (ctl && t && i_op > 4'h6
		|=> !o_done ##1 o_pc_we && o_pc == $past(tgt, 2)) else $error("branch");
	fall_through_a: assert property (ctl && !t
		|=> o_done && o_pc_we && o_pc == $past(i_pc) + 1'b1) else $error("fall");
	no_flag_write_a: assert property (ctl |=> !o_flags_we)
		else $error("flags written");
	flag_cause_a: assert property (o_flags_we |-> o_done && $past(acc)
		&& $past(i_op) inside {4'h1, 4'h2}) else $error("stray flags");
	pc_with_done_a: assert property (o_pc_we |-> o_done)
		else $error("pc load without done");
endmodule
bind compare_skip_branch_unit csb_checker #(.PC_W(PC_W)) i_csb_checker (
	.i_clk, .i_sys_rst, .i_issue, .i_next_is_long, .o_done, .o_pc_we,
	.o_flags_we, .i_op, .i_source_work_reg, .i_io_reg, .i_status_flag_register,
	.i_bit_sel, .i_offset, .i_pc, .o_pc);
`default_nettype wire
